/* File: src/agf_cfg.svh */
// Constants for the A-scan gate, alarm and freeze evaluation block
`ifndef AGF_CFG_SVH
`define AGF_CFG_SVH
`define AGF_AMP_W      8
`define AGF_IDX_W      10
`define AGF_POINTS     10'h320
`define AGF_LAST_PT    10'h31F
`define AGF_DISP_RATE  16'h003C
`define AGF_PRF_W      16
`define AGF_MIN_ZOOM   10'h010
`define AGF_FIFO_DEPTH 8
`define AGF_FIFO_AW    3
`define AGF_AMP_ZERO   8'h00
`define AGF_IDX_ZERO   10'h000
`define AGF_CNT_ZERO   16'h0000
`define AGF_CNT_ONE    16'h0001
`define AGF_W_ONE      10'h001
`endif

/* File: src/agf_pkg.sv */
// Types for the A-scan gate, alarm and freeze evaluation block
package agf_pkg;
  typedef enum logic [1:0] {AGF_LOGIC_OFF, AGF_LOGIC_POS, AGF_LOGIC_NEG} agf_logic_e;
  typedef enum logic [2:0] {
    AGF_FRZ_STANDARD, AGF_FRZ_GATE_A, AGF_FRZ_GATE_B, AGF_FRZ_EITHER, AGF_FRZ_COMPARE
  } agf_freeze_e;
  typedef enum logic [2:0] {
    AGF_OUT_A_POS, AGF_OUT_B_POS, AGF_OUT_AB_POS, AGF_OUT_A_NEG, AGF_OUT_B_NEG,
    AGF_OUT_AB_NEG
  } agf_outsel_e;
  typedef enum logic [1:0] {AGF_ST_LIVE, AGF_ST_HOLD} agf_state_e;
endpackage

/* File: src/agf_fifo.sv */
// Small flip-flop FIFO for the display sample stream
`timescale 1ns/1ps
`include "agf_cfg.svh"
module agf_fifo #(
  parameter int W  = 18,
  parameter int D  = `AGF_FIFO_DEPTH,
  parameter int AW = `AGF_FIFO_AW
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [D];
  logic [AW:0]  wr_reg;
  logic [AW:0]  rd_reg;
  wire          full_w  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire          empty_w = (wr_reg == rd_reg);
  wire          push_w  = in_valid && !full_w;
  wire          pop_w   = out_valid && out_ready;
  assign in_ready  = !full_w;
  assign out_valid = !empty_w;
  assign out_data  = mem_reg[rd_reg[AW-1:0]];
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push_w) wr_reg <= wr_reg + 1'b1;
      if (pop_w) rd_reg <= rd_reg + 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (push_w) mem_reg[wr_reg[AW-1:0]] <= in_data;
  end
endmodule

/* File: src/agf_eval.sv */
// Gate evaluation, alarms, freeze, peak-hold merging and gate zoom
//
// Contract
// - Gate-A auto setting holds the trace once the echo touches gate A.
// - Gate-B auto setting holds the trace once the echo touches gate B.
// - Either-gate auto setting holds once the echo touches gate A or B.
// - Compare mode shows a frozen trace behind the live one.
// - Compare mode stores the latest trace as reference when freeze is left; here each key press books the next whole trace.
// - With gate B referenced to A, no freeze before the echo reaches A.
// - A brief key press toggles between held and live trace.
// - Without merging, pass only a subset of raw traces, uncombined.
// - With merging and rate above 60 Hz, keep per-point maxima over 800 points.
// - Merge rate divided by 60 raw traces into one trace.
// - At 60 Hz or below, never merge traces.
// - Gate logic off disables its alarm, measurement and drawing.
// - Positive gate logic alarms when the echo exceeds the gate.
// - Negative gate logic alarms when the echo misses the gate.
// - Output sources A(+) and B(+) fire when that gate is exceeded.
// - Output sources A(-) and B(-) fire when that gate is not reached.
// - Combined positive output source is the OR of both exceeded.
// - Combined negative output source is the AND of both not reached.
// - Output polarity is set apart from the indicator gate polarity.
// - Only gates A and B feed the alarm output.
// - Gate zoom maps the chosen gate onto the whole display.
// - Gate zoom is refused with an error when the gate is too narrow.
// - Onscreen lamp is green without alarm and red with alarm.
`timescale 1ns/1ps
`include "agf_cfg.svh"
module agf_eval (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  // Trace samples from the acquisition front end, point 0 first
  input  wire logic                     smp_valid,
  input  wire logic [`AGF_AMP_W-1:0]    smp_amp,
  input  wire logic [`AGF_IDX_W-1:0]    smp_idx,
  input  wire logic                     smp_last,
  input  wire logic [`AGF_PRF_W-1:0]    prf_hz,
  // Gate settings
  input  wire logic [`AGF_IDX_W-1:0]    gate_a_start,
  input  wire logic [`AGF_IDX_W-1:0]    gate_a_end,
  input  wire logic [`AGF_AMP_W-1:0]    gate_a_thr,
  input  wire agf_pkg::agf_logic_e      gate_a_logic,
  input  wire logic [`AGF_IDX_W-1:0]    gate_b_start,
  input  wire logic [`AGF_IDX_W-1:0]    gate_b_end,
  input  wire logic [`AGF_AMP_W-1:0]    gate_b_thr,
  input  wire agf_pkg::agf_logic_e      gate_b_logic,
  input  wire logic                     gate_b_from_a,
  input  wire agf_pkg::agf_freeze_e     freeze_mode,
  input  wire agf_pkg::agf_outsel_e     out_select,
  input  wire logic                     peak_merge_en,
  input  wire logic                     freeze_key,
  input  wire logic                     zoom_key,
  input  wire logic                     zoom_gate_b,
  // Display side
  output logic                          disp_valid,
  input  wire logic                     disp_ready,
  output logic [`AGF_AMP_W-1:0]         disp_amp,
  output logic [`AGF_IDX_W-1:0]         disp_idx,
  output logic [`AGF_AMP_W-1:0]         disp_ref_amp,
  output logic                          disp_ref_show,
  output logic                          hold_active,
  output logic                          draw_gate_a,
  output logic                          draw_gate_b,
  output logic                          zoom_active,
  output logic [`AGF_IDX_W-1:0]         zoom_start,
  output logic [`AGF_IDX_W-1:0]         zoom_width,
  output logic                          zoom_error,
  output logic                          gate_a_alarm,
  output logic                          gate_b_alarm,
  output logic                          onscreen_alarm_lamp,
  output logic                          alarm_out
);
  // ****************************************
  // Gate window test
  // ****************************************
  logic [`AGF_AMP_W-1:0] peak_mem_reg [`AGF_POINTS];
  logic [`AGF_AMP_W-1:0] ref_mem_reg  [`AGF_POINTS];
  logic                  hit_a_reg;
  logic                  hit_b_reg;
  logic                  hit_a_next;
  logic                  hit_b_next;
  logic [`AGF_PRF_W-1:0] merge_cnt_reg;
  logic                  hold_reg;
  logic                  armed_a_reg;
  logic                  key_d_reg;
  logic                  zkey_d_reg;
  logic                  cap_pend_reg;
  logic                  cap_run_reg;
  agf_pkg::agf_state_e   state_reg;

  wire in_a_w = (smp_idx >= gate_a_start) && (smp_idx <= gate_a_end);
  wire in_b_w = (smp_idx >= gate_b_start) && (smp_idx <= gate_b_end);
  wire above_a_w = smp_valid && in_a_w && (smp_amp > gate_a_thr);
  wire above_b_w = smp_valid && in_b_w && (smp_amp > gate_b_thr);
  wire a_on_w = (gate_a_logic != agf_pkg::AGF_LOGIC_OFF);
  wire b_on_w = (gate_b_logic != agf_pkg::AGF_LOGIC_OFF);
  wire first_w = smp_valid && (smp_idx == `AGF_IDX_ZERO);
  wire end_w = smp_valid && smp_last;

  // Per-trace hit, restarted at point zero so the trace is judged whole
  assign hit_a_next = (first_w ? 1'b0 : hit_a_reg) | above_a_w;
  assign hit_b_next = (first_w ? 1'b0 : hit_b_reg) | above_b_w;

  // ****************************************
  // Alarms and output source
  // ****************************************
  wire exc_a_w = a_on_w && hit_a_next;
  wire exc_b_w = b_on_w && hit_b_next;
  wire miss_a_w = a_on_w && !hit_a_next;
  wire miss_b_w = b_on_w && !hit_b_next;
  wire alm_a_w = (gate_a_logic == agf_pkg::AGF_LOGIC_POS) ? exc_a_w :
                 (gate_a_logic == agf_pkg::AGF_LOGIC_NEG) ? miss_a_w : 1'b0;
  wire alm_b_w = (gate_b_logic == agf_pkg::AGF_LOGIC_POS) ? exc_b_w :
                 (gate_b_logic == agf_pkg::AGF_LOGIC_NEG) ? miss_b_w : 1'b0;
  // Alarms settle once per trace and freeze with the display; off clears gate_a_alarm and gate_b_alarm at once, alarm_out at trace end
  wire alm_take_w = end_w && !hold_reg;
  wire a_alarm_next_w = a_on_w && (alm_take_w ? alm_a_w : gate_a_alarm);
  wire b_alarm_next_w = b_on_w && (alm_take_w ? alm_b_w : gate_b_alarm);
  logic out_w;
  // Output polarity comes from out_select only, gate C has no input here
  always_comb begin
    case (out_select)
      agf_pkg::AGF_OUT_A_POS:  out_w = exc_a_w;
      agf_pkg::AGF_OUT_B_POS:  out_w = exc_b_w;
      agf_pkg::AGF_OUT_AB_POS: out_w = exc_a_w | exc_b_w;
      agf_pkg::AGF_OUT_A_NEG:  out_w = miss_a_w;
      agf_pkg::AGF_OUT_B_NEG:  out_w = miss_b_w;
      agf_pkg::AGF_OUT_AB_NEG: out_w = miss_a_w & miss_b_w;
      default:                 out_w = 1'b0;
    endcase
  end

  // ****************************************
  // Freeze control
  // ****************************************
  wire key_press_w = freeze_key && !key_d_reg;
  // With gate_b_from_a set, gate B only counts once the interface echo has armed it through gate A
  wire b_ok_w = !gate_b_from_a || armed_a_reg || exc_a_w;
  logic auto_w;
  always_comb begin
    case (freeze_mode)
      agf_pkg::AGF_FRZ_GATE_A: auto_w = exc_a_w;
      agf_pkg::AGF_FRZ_GATE_B: auto_w = exc_b_w && b_ok_w;
      agf_pkg::AGF_FRZ_EITHER: auto_w = exc_a_w || (exc_b_w && b_ok_w);
      default:                 auto_w = 1'b0;
    endcase
  end
  wire auto_hold_w = end_w && auto_w;
  wire compare_w = (freeze_mode == agf_pkg::AGF_FRZ_COMPARE);
  // A key press in compare mode books the next whole trace as the reference
  wire cap_w = first_w ? cap_pend_reg : cap_run_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= agf_pkg::AGF_ST_LIVE;
      key_d_reg <= 1'b0;
      armed_a_reg <= 1'b0;
      cap_pend_reg <= 1'b0;
      cap_run_reg <= 1'b0;
    end else begin
      key_d_reg <= freeze_key;
      if (compare_w && key_press_w) cap_pend_reg <= 1'b1;
      else if (first_w) cap_pend_reg <= 1'b0;
      if (end_w) cap_run_reg <= 1'b0;
      else if (first_w) cap_run_reg <= cap_pend_reg;
      if (end_w) armed_a_reg <= 1'b0;
      else if (exc_a_w) armed_a_reg <= 1'b1;
      case (state_reg)
        agf_pkg::AGF_ST_LIVE: begin
          if (key_press_w || auto_hold_w) state_reg <= agf_pkg::AGF_ST_HOLD;
        end
        agf_pkg::AGF_ST_HOLD: begin
          if (key_press_w) state_reg <= agf_pkg::AGF_ST_LIVE;
        end
        default: state_reg <= agf_pkg::AGF_ST_LIVE;
      endcase
    end
  end
  // Compare mode keeps the live trace moving; other modes stop it
  wire hold_w = (state_reg == agf_pkg::AGF_ST_HOLD) && !compare_w;

  // ****************************************
  // Peak-hold merging
  // ****************************************
  wire merge_w = peak_merge_en && (prf_hz > `AGF_DISP_RATE);
  wire [`AGF_PRF_W-1:0] group_w = prf_hz / `AGF_DISP_RATE;
  wire group_first_w = (merge_cnt_reg == `AGF_CNT_ZERO);
  wire group_last_w = !merge_w || (merge_cnt_reg + `AGF_CNT_ONE >= group_w);
  wire [`AGF_AMP_W-1:0] old_w = peak_mem_reg[smp_idx];
  wire [`AGF_AMP_W-1:0] max_w = (group_first_w || smp_amp > old_w) ? smp_amp : old_w;
  wire fifo_ready_w;
  // Without merging, a trace is dropped from the first sample that finds the display busy to its end
  logic pass_reg;
  wire pass_w = first_w ? fifo_ready_w : pass_reg;
  wire send_w = smp_valid && !hold_w && pass_w && group_last_w && fifo_ready_w;
  wire in_pts_w = (smp_idx <= `AGF_LAST_PT);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      merge_cnt_reg <= `AGF_CNT_ZERO;
      pass_reg <= 1'b1;
      hit_a_reg <= 1'b0;
      hit_b_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= hold_w;
      if (smp_valid) begin
        hit_a_reg <= hit_a_next;
        hit_b_reg <= hit_b_next;
      end
      if (first_w) pass_reg <= fifo_ready_w;
      else if (smp_valid && !fifo_ready_w && group_last_w) pass_reg <= 1'b0;
      if (end_w && !hold_w)
        merge_cnt_reg <= group_last_w ? `AGF_CNT_ZERO : merge_cnt_reg + `AGF_CNT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (smp_valid && in_pts_w && !hold_w) peak_mem_reg[smp_idx] <= max_w;
    // Reference is written only by a booked trace and then kept on screen
    if (smp_valid && in_pts_w && cap_w) ref_mem_reg[smp_idx] <= smp_amp;
  end

  // ****************************************
  // Display FIFO and zoom
  // ****************************************
  logic [`AGF_AMP_W+`AGF_AMP_W+`AGF_IDX_W-1:0] fifo_out_w;
  logic fifo_valid_w;
  agf_fifo #(.W(`AGF_AMP_W + `AGF_AMP_W + `AGF_IDX_W)) u_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (send_w),
    .in_ready  (fifo_ready_w),
    .in_data   ({max_w, ref_mem_reg[smp_idx], smp_idx}),
    .out_valid (fifo_valid_w),
    .out_ready (disp_ready || !disp_valid),
    .out_data  (fifo_out_w)
  );
  wire [`AGF_IDX_W-1:0] zs_w = zoom_gate_b ? gate_b_start : gate_a_start;
  wire [`AGF_IDX_W-1:0] zw_w = (zoom_gate_b ? gate_b_end : gate_a_end) - zs_w + `AGF_W_ONE;
  wire zgate_on_w = zoom_gate_b ? b_on_w : a_on_w;
  wire znarrow_w = (zw_w < `AGF_MIN_ZOOM) || !zgate_on_w;
  wire zpress_w = zoom_key && !zkey_d_reg;
  wire zoom_next_w = zpress_w ? (!zoom_active && !znarrow_w) : zoom_active;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      disp_valid <= 1'b0;
      disp_amp <= `AGF_AMP_ZERO;
      disp_idx <= `AGF_IDX_ZERO;
      disp_ref_amp <= `AGF_AMP_ZERO;
      disp_ref_show <= 1'b0;
      hold_active <= 1'b0;
      draw_gate_a <= 1'b0;
      draw_gate_b <= 1'b0;
      zkey_d_reg <= 1'b0;
      zoom_active <= 1'b0;
      zoom_start <= `AGF_IDX_ZERO;
      zoom_width <= `AGF_POINTS;
      zoom_error <= 1'b0;
      gate_a_alarm <= 1'b0;
      gate_b_alarm <= 1'b0;
      onscreen_alarm_lamp <= 1'b0;
      alarm_out <= 1'b0;
    end else begin
      if (fifo_valid_w && (disp_ready || !disp_valid)) begin
        disp_valid <= 1'b1;
        {disp_amp, disp_ref_amp, disp_idx} <= fifo_out_w;
      end else if (disp_ready) begin
        disp_valid <= 1'b0;
      end
      disp_ref_show <= compare_w;
      hold_active <= hold_w;
      draw_gate_a <= a_on_w;
      draw_gate_b <= b_on_w;
      zkey_d_reg <= zoom_key;
      zoom_error <= zpress_w && !zoom_active && znarrow_w;
      zoom_active <= zoom_next_w;
      if (!zoom_next_w) begin
        zoom_start <= `AGF_IDX_ZERO;
        zoom_width <= `AGF_POINTS;
      end else if (!zoom_active) begin
        zoom_start <= zs_w;
        zoom_width <= zw_w;
      end
      gate_a_alarm <= a_alarm_next_w;
      gate_b_alarm <= b_alarm_next_w;
      onscreen_alarm_lamp <= a_alarm_next_w | b_alarm_next_w;
      if (alm_take_w) alarm_out <= out_w;
    end
  end
endmodule

/* File: verification/agf_eval_props.sv */
// Port assertions for the gate, alarm and freeze evaluation block
`timescale 1ns/1ps
module agf_eval_props (
  input wire logic                 core_clk,
  input wire logic                 reset_n,
  input wire logic                 smp_valid,
  input wire logic [7:0]           smp_amp,
  input wire logic [9:0]           smp_idx,
  input wire logic                 smp_last,
  input wire logic [9:0]           gate_a_start,
  input wire logic [9:0]           gate_a_end,
  input wire logic [7:0]           gate_a_thr,
  input wire agf_pkg::agf_logic_e  gate_a_logic,
  input wire agf_pkg::agf_logic_e  gate_b_logic,
  input wire logic                 disp_valid,
  input wire logic                 disp_ready,
  input wire logic [7:0]           disp_amp,
  input wire logic [9:0]           disp_idx,
  input wire logic                 hold_active,
  input wire logic                 draw_gate_a,
  input wire logic                 draw_gate_b,
  input wire logic                 zoom_active,
  input wire logic [9:0]           zoom_start,
  input wire logic [9:0]           zoom_width,
  input wire logic                 zoom_error,
  input wire logic                 gate_a_alarm,
  input wire logic                 gate_b_alarm,
  input wire logic                 onscreen_alarm_lamp,
  input wire logic                 alarm_out
);
  logic hit_a_reg;
  wire  in_a = smp_valid && smp_idx >= gate_a_start && smp_idx <= gate_a_end
               && smp_amp > gate_a_thr;
  // Sticky per-trace hit, cleared by point 0 of the next trace
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) hit_a_reg <= 1'b0;
    else if (smp_valid) hit_a_reg <= (smp_idx != 10'h000 && hit_a_reg) || in_a;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_alarm_a;
    smp_valid && smp_last && !hold_active && gate_a_logic == agf_pkg::AGF_LOGIC_POS
      |=> gate_a_alarm == hit_a_reg;
  endproperty
  property p_alarm_keep;
    !(smp_valid && smp_last) && gate_a_logic != agf_pkg::AGF_LOGIC_OFF
      && gate_b_logic != agf_pkg::AGF_LOGIC_OFF
      |=> $stable(gate_a_alarm) && $stable(gate_b_alarm) && $stable(alarm_out);
  endproperty
  property p_off; gate_a_logic == agf_pkg::AGF_LOGIC_OFF [*2] |-> !draw_gate_a; endproperty
  property p_on; gate_b_logic != agf_pkg::AGF_LOGIC_OFF [*2] |-> draw_gate_b; endproperty
  property p_lamp; onscreen_alarm_lamp == (gate_a_alarm || gate_b_alarm); endproperty
  property p_zerr; zoom_error |-> !zoom_active ##1 !zoom_error; endproperty
  property p_zidle; !zoom_active |-> zoom_start == 10'h000 && zoom_width == 10'h320; endproperty
  property p_disp;
    disp_valid && !disp_ready |=> disp_valid && $stable(disp_amp) && $stable(disp_idx);
  endproperty
  a_alarm_a: assert property (p_alarm_a) else $error("gate A alarm wrong");
  a_alarm_keep: assert property (p_alarm_keep) else $error("alarm moved mid trace");
  a_off: assert property (p_off) else $error("gate A drawn while off");
  a_on: assert property (p_on) else $error("gate B not drawn");
  a_lamp: assert property (p_lamp) else $error("lamp disagrees with alarms");
  a_zerr: assert property (p_zerr) else $error("zoom error not a refusal pulse");
  a_zidle: assert property (p_zidle) else $error("idle zoom window wrong");
  a_disp: assert property (p_disp) else $error("display word dropped while stalled");
  c_hold: cover property ($rose(hold_active));
  c_zoom: cover property ($rose(zoom_active));
  c_zerr: cover property (zoom_error);
endmodule
bind agf_eval agf_eval_props u_props (.*);

/* File: verification/agf_front_model.sv */
// Acquisition front end and display sink model
`timescale 1ns/1ps
module agf_front_model (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [7:0] amp_a,
  input  wire logic [7:0] amp_b,
  output logic            smp_valid,
  output logic [7:0]      smp_amp,
  output logic [9:0]      smp_idx,
  output logic            smp_last,
  output logic            disp_ready,
  output logic            busy
);
  logic [10:0] step;
  logic [1:0]  tick;
  initial begin
    {smp_valid, smp_last, busy, disp_ready} = 4'h0;
    smp_amp = 8'h00;
    smp_idx = 10'h000;
    step = 11'h000;
    tick = 2'h0;
  end
  // One sample every other cycle, so the 3-in-4 display drain never lets the FIFO fill
  always @(negedge core_clk) begin
    tick <= tick + 2'h1;
    disp_ready <= tick != 2'h3;
    smp_valid <= busy && !step[0];
    smp_last <= busy && step == 11'h63E;
    smp_idx <= step[10:1];
    if (!busy || step[0]) smp_amp <= ~smp_amp;
    else smp_amp <= step[10:1] == 10'h096 ? amp_a : step[10:1] == 10'h1C2 ? amp_b : 8'h10;
    step <= busy ? step + 11'h001 : 11'h000;
    if (go && !busy) busy <= 1'b1;
    else if (step == 11'h63E) busy <= 1'b0;
  end
endmodule

/* File: verification/agf_eval_tb.sv */
// Self-checking bench for the gate, alarm and freeze evaluation block
`timescale 1ns/1ps
module agf_eval_tb;
  logic core_clk, reset_n, go, busy, smp_valid, smp_last, disp_ready, freeze_key, zoom_key;
  logic zoom_gate_b, peak_merge_en, gate_b_from_a, ea, eb, zerr_seen;
  logic disp_valid, disp_ref_show, hold_active, draw_gate_a, draw_gate_b, zoom_active;
  logic zoom_error, gate_a_alarm, gate_b_alarm, onscreen_alarm_lamp, alarm_out;
  logic [7:0] smp_amp, amp_a, amp_b, gate_a_thr, gate_b_thr, disp_amp, disp_ref_amp, last150;
  logic [9:0] smp_idx, gate_a_start, gate_a_end, gate_b_start, gate_b_end, disp_idx;
  logic [9:0] zoom_start, zoom_width;
  logic [7:0] ref150;
  logic [15:0] prf_hz;
  agf_pkg::agf_logic_e gate_a_logic, gate_b_logic;
  agf_pkg::agf_freeze_e freeze_mode;
  agf_pkg::agf_outsel_e out_select;
  agf_pkg::agf_freeze_e fmode [5] = '{agf_pkg::AGF_FRZ_GATE_A, agf_pkg::AGF_FRZ_GATE_B,
    agf_pkg::AGF_FRZ_GATE_B, agf_pkg::AGF_FRZ_EITHER, agf_pkg::AGF_FRZ_EITHER};
  logic [7:0] fa [5] = '{8'h80, 8'h80, 8'h10, 8'h10, 8'h10};
  logic [7:0] fb [5] = '{8'h10, 8'h10, 8'h80, 8'h80, 8'h10};
  logic [4:0] fexp = 5'h0D;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  agf_eval uut (.*);
  agf_front_model fm (.*);
  // ****************
  // Tasks
  // ****************
  task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task trace(input logic [7:0] a, input logic [7:0] b);
    @(negedge core_clk);
    amp_a <= a;
    amp_b <= b;
    go <= 1'b1;
    @(negedge core_clk);
    go <= 1'b0;
    repeat (2) @(negedge core_clk);
    while (busy) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask
  task press(input logic zk);
    @(negedge core_clk);
    if (zk) zoom_key = 1'b1;
    else freeze_key = 1'b1;
    repeat (3) @(negedge core_clk);
    {zoom_key, freeze_key} = 2'h0;
    repeat (3) @(negedge core_clk);
  endtask
  function logic exp_out(input int s, input logic a, input logic b);
    case (s)
      0: return a;
      1: return b;
      2: return a | b;
      3: return !a;
      4: return !b;
      default: return !a & !b;
    endcase
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Timeout sized for about 36 traces of 1600 cycles each, with margin
  always @(posedge core_clk) begin
    cycles++;
    if (disp_valid && disp_ready && disp_idx == 10'h096) begin
      last150 <= disp_amp;
      ref150 <= disp_ref_amp;
    end
    if (zoom_error) zerr_seen <= 1'b1;
    if (cycles == 80000) begin
      num_errors++;
      stop_test();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    {reset_n, go, freeze_key, zoom_key, zoom_gate_b, peak_merge_en, gate_b_from_a} = 7'h00;
    {amp_a, amp_b, last150, zerr_seen, prf_hz} = {8'h10, 8'h10, 8'h00, 1'b0, 16'h003C};
    ref150 = 8'h00;
    {gate_a_start, gate_a_end, gate_a_thr} = {10'h064, 10'h0C7, 8'h40};
    {gate_b_start, gate_b_end, gate_b_thr} = {10'h190, 10'h1F3, 8'h40};
    gate_a_logic = agf_pkg::AGF_LOGIC_POS;
    gate_b_logic = agf_pkg::AGF_LOGIC_NEG;
    freeze_mode = agf_pkg::AGF_FRZ_STANDARD;
    out_select = agf_pkg::AGF_OUT_A_POS;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    chk("zoom_width", 10'h320, zoom_width);
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 6; s++) begin
        ea = p == 0;
        eb = p == 1;
        out_select = agf_pkg::agf_outsel_e'(s);
        trace(ea ? 8'h80 : 8'h10, eb ? 8'h80 : 8'h10);
        chk("alarm_out", {9'h000, exp_out(s, ea, eb)}, alarm_out);
        chk("gate_a_alarm", {9'h000, ea}, gate_a_alarm);
        chk("gate_b_alarm", {9'h000, !eb}, gate_b_alarm);
        chk("onscreen_alarm_lamp", {9'h000, ea | !eb}, onscreen_alarm_lamp);
      end
    end
    gate_a_logic = agf_pkg::AGF_LOGIC_OFF;
    trace(8'h80, 8'h10);
    chk("gate_a_alarm", 10'h000, gate_a_alarm);
    chk("draw_gate_a", 10'h000, draw_gate_a);
    gate_a_logic = agf_pkg::AGF_LOGIC_POS;
    for (int i = 0; i < 5; i++) begin
      freeze_mode = fmode[i];
      trace(fa[i], fb[i]);
      chk("hold_active", {9'h000, fexp[i]}, hold_active);
      freeze_mode = agf_pkg::AGF_FRZ_STANDARD;
      if (fexp[i]) press(1'b0);
      chk("hold_active", 10'h000, hold_active);
    end
    gate_b_from_a = 1'b1;
    freeze_mode = agf_pkg::AGF_FRZ_GATE_B;
    trace(8'h10, 8'h80);
    chk("hold_active", 10'h000, hold_active);
    trace(8'h80, 8'h80);
    chk("hold_active", 10'h001, hold_active);
    trace(8'h20, 8'h10);
    chk("held_peak", 10'h080, {2'h0, last150});
    gate_b_from_a = 1'b0;
    freeze_mode = agf_pkg::AGF_FRZ_STANDARD;
    press(1'b0);
    chk("hold_active", 10'h000, hold_active);
    press(1'b0);
    chk("hold_active", 10'h001, hold_active);
    press(1'b0);
    freeze_mode = agf_pkg::AGF_FRZ_COMPARE;
    press(1'b0);
    trace(8'h70, 8'h10);
    trace(8'h50, 8'h10);
    chk("hold_active", 10'h000, hold_active);
    chk("live_peak", 10'h050, {2'h0, last150});
    chk("ref_peak", 10'h070, {2'h0, ref150});
    chk("disp_ref_show", 10'h001, disp_ref_show);
    press(1'b0);
    trace(8'h30, 8'h10);
    trace(8'h20, 8'h10);
    trace(8'h20, 8'h10);
    chk("ref_peak", 10'h030, {2'h0, ref150});
    chk("disp_ref_show", 10'h001, disp_ref_show);
    freeze_mode = agf_pkg::AGF_FRZ_STANDARD;
    press(1'b1);
    chk("zoom_active", 10'h001, zoom_active);
    chk("zoom_start", 10'h064, zoom_start);
    chk("zoom_width", 10'h064, zoom_width);
    press(1'b1);
    chk("zoom_active", 10'h000, zoom_active);
    chk("zoom_width", 10'h320, zoom_width);
    gate_b_end = 10'h19A;
    zoom_gate_b = 1'b1;
    press(1'b1);
    chk("zoom_error", 10'h001, {9'h000, zerr_seen});
    chk("zoom_active", 10'h000, zoom_active);
    {peak_merge_en, prf_hz} = {1'b1, 16'h0078};
    trace(8'h80, 8'h10);
    trace(8'h60, 8'h10);
    chk("merged_peak", 10'h080, {2'h0, last150});
    prf_hz = 16'h003C;
    trace(8'h80, 8'h10);
    trace(8'h60, 8'h10);
    chk("unmerged_peak", 10'h060, {2'h0, last150});
    stop_test();
  end
endmodule
